// File: design/sse_clkdiv.sv
// file: half-period enable divider for the serial clock
`timescale 1ns/1ps
module sse_clkdiv
   import sse_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic run,
   output logic      tick
);
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;

   // restart from zero whenever stopped so every bit gets a full half period
   assign tick     = run && (cnt_reg == DIV_LAST);
   assign cnt_next = (!run || tick) ? '0 : cnt_reg + DIV_W'(1);

   // counter
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : sse_clkdiv

// File: design/sse_master.sv
// file: spi master that exchanges bytes with one selected slave
`timescale 1ns/1ps
// Overview of operation
// - one byte register sends and receives
// - msb out first, new bit into lsb
// - change on one edge, sample opposite
// - mosi feeds slave, miso feeds master
// - only master makes clock, starting transfers
// - both ends share idle clock polarity
// - after eight clocks bytes fully swapped
// - reload register with next byte, repeat
// - stop clock, then drop select
// - at most one select active
// - separate select per slave
module sse_master
   import sse_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 cpol,
   input  wire logic                 cpha,
   input  wire sse_req_t             req,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   output logic [BYTE_BITS-1:0]      rx_data,
   output logic                      rx_valid,
   output logic                      busy,
   input  wire logic                 miso,
   output sse_pins_t                 pins
);
   sse_state_t             state_reg, state_next;
   logic [BYTE_BITS-1:0]   shift_reg;
   logic [CNT_W-1:0]       cnt_reg;
   logic [SEL_W-1:0]       slave_reg;
   logic                   last_reg;
   logic                   cpol_reg;
   logic                   cpha_reg;
   logic                   miso_s1_reg;
   logic                   miso_s2_reg;
   logic                   sample_reg;
   logic                   sck_reg;
   logic                   mosi_reg;
   logic [NUM_SLAVES-1:0]  sel_n_reg;
   logic [BYTE_BITS-1:0]   rx_data_reg;
   logic                   rx_valid_reg;
   logic                   tick;
   logic                   run;
   logic                   take;
   logic                   byte_end;
   logic                   chain;
   logic                   word_end;
   logic                   stall_reg;
   logic                   lead_tick;
   logic                   trail_tick;
   logic                   smp_tick;
   logic                   shf_tick;
   logic [BYTE_BITS-1:0]   rx_word;

   // one-hot active-low select from the slave index
   function automatic logic [NUM_SLAVES-1:0] sel_decode(input logic [SEL_W-1:0] idx);
      logic [NUM_SLAVES-1:0] v;
      v = SEL_NONE;
      v[idx] = 1'b0;
      return v;
   endfunction : sel_decode

   sse_clkdiv u_div (
      .clk  (clk),
      .srst (srst),
      .run  (run),
      .tick (tick)
   );

   // the link is generated here; miso is asynchronous to us, so two flops first
   always_ff @(posedge clk) begin
      if (srst) begin
         miso_s1_reg <= 1'b0;
         miso_s2_reg <= 1'b0;
      end else begin
         miso_s1_reg <= miso;
         miso_s2_reg <= miso_s1_reg;
      end
   end

   // a chained byte is offered at every closing trail tick, so a late request still resumes a stall
   assign run       = (state_reg != SSE_IDLE);
   assign word_end  = tick && (state_reg == SSE_TRAIL) && (cnt_reg == CNT_LAST);
   assign req_ready = (state_reg == SSE_IDLE) || (word_end && !last_reg);
   assign take      = req_valid && (state_reg == SSE_IDLE);
   assign byte_end  = word_end && !stall_reg;
   assign chain     = word_end && !last_reg && req_valid;
   assign busy      = run;
   assign rx_data   = rx_data_reg;
   assign rx_valid  = rx_valid_reg;
   assign pins      = '{sck: sck_reg, mosi: mosi_reg, sel_n: sel_n_reg};

   // edge ticks; phase 0 samples on the lead edge and shifts on the trail edge, phase 1 the other way round
   assign lead_tick  = tick && (state_reg == SSE_LEAD);
   assign trail_tick = tick && (state_reg == SSE_TRAIL) && !stall_reg;
   assign smp_tick   = cpha_reg ? trail_tick : lead_tick;
   // phase 1 skips the first lead shift: the msb must stand until the slave has sampled it
   assign shf_tick   = cpha_reg ? (lead_tick && cnt_reg != CNT_ZERO) : trail_tick;
   // the last bit of phase 1 arrives on the closing trail edge and has no later shift to carry it
   assign rx_word    = cpha_reg ? {shift_reg[BYTE_BITS-2:0], miso_s2_reg}
                                : {shift_reg[BYTE_BITS-2:0], sample_reg};

   // stall marker: the byte is already reported, so a waiting trail must neither
   // report it again nor shift stale samples into the register
   always_ff @(posedge clk) begin
      if (srst || take || chain) begin
         stall_reg <= 1'b0;
      end else if (byte_end && !last_reg) begin
         stall_reg <= 1'b1;
      end
   end

   // lead half ends on first edge, trail half on second; gap holds select after clock stops
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SSE_IDLE:  if (take) state_next = SSE_LEAD;
         SSE_LEAD:  if (tick) state_next = SSE_TRAIL;
         SSE_TRAIL: if (tick) state_next = (cnt_reg != CNT_LAST || chain) ? SSE_LEAD
                                     : (last_reg ? SSE_GAP : SSE_TRAIL);
         SSE_GAP:   if (tick) state_next = SSE_IDLE;
      endcase
   end

   // state register; a mid-burst stall waits in trail with clock idle
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= SSE_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // config is latched per burst so polarity never changes under a selected slave
   always_ff @(posedge clk) begin
      if (srst) begin
         cpol_reg  <= 1'b0;
         cpha_reg  <= 1'b0;
         slave_reg <= '0;
      end else if (take) begin
         cpol_reg  <= cpol;
         cpha_reg  <= cpha;
         slave_reg <= req.slave;
      end
   end

   // bit counter and last-byte marker
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg  <= CNT_ZERO;
         last_reg <= 1'b1;
      end else if (take || chain) begin
         cnt_reg  <= CNT_ZERO;
         last_reg <= req.last;
      end else if (tick && state_reg == SSE_TRAIL && cnt_reg != CNT_LAST) begin
         cnt_reg  <= cnt_reg + CNT_W'(1);
      end
   end

   // shift register: load, sample on first or second edge by phase, shift msb out
   always_ff @(posedge clk) begin
      if (srst) begin
         shift_reg  <= '0;
         sample_reg <= 1'b0;
      end else if (take || chain) begin
         shift_reg  <= req.data;
      end else begin
         // sample and shift never share a tick, the phase puts them on opposite edges
         if (smp_tick) begin
            sample_reg <= miso_s2_reg;
         end
         if (shf_tick) begin
            shift_reg <= {shift_reg[BYTE_BITS-2:0], sample_reg};
         end
      end
   end

   // pins: clock toggles only between lead and trail, mosi shows current msb
   always_ff @(posedge clk) begin
      if (srst) begin
         sck_reg   <= 1'b0;
         mosi_reg  <= 1'b0;
         sel_n_reg <= SEL_NONE;
      end else begin
         // idle level follows the polarity input a cycle late, so it has settled when a select falls only if cpol was steady before the take cycle
         if (state_reg == SSE_IDLE) begin
            sck_reg <= cpol;
         end else if (lead_tick || (tick && state_reg == SSE_TRAIL)) begin
            sck_reg <= lead_tick ? ~cpol_reg : cpol_reg;
         end
         // mosi trails each shift by one cycle, well inside the half period
         mosi_reg <= shift_reg[BYTE_BITS-1];
         if (take) begin
            sel_n_reg <= sel_decode(req.slave);
         end else if (state_reg == SSE_GAP && tick) begin
            sel_n_reg <= SEL_NONE;
         end
      end
   end

   // byte done pulse with the exchanged byte
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_data_reg  <= '0;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= byte_end;
         if (byte_end) begin
            rx_data_reg <= rx_word;
         end
      end
   end
endmodule : sse_master

// File: design/sse_pkg.sv
// package: shared constants and types for the spi shift exchange master
package sse_pkg;
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned SCK_HALF_NS   = 400;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   // half period of the serial clock in system cycles, rounded down, at least one
   localparam int unsigned HALF_CYC_RAW  = SCK_HALF_NS / CLK_PERIOD_NS;
   localparam int unsigned HALF_CYC      = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
   localparam int unsigned BYTE_BITS     = 8;
   localparam int unsigned NUM_SLAVES    = 4;
   localparam int unsigned SEL_W         = 2;
   localparam int unsigned DIV_W         = 8;
   localparam int unsigned CNT_W         = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BYTE_BITS - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [NUM_SLAVES-1:0] SEL_NONE = 4'hf;

   // user request: byte to send, slave index, last byte of the burst
   typedef struct packed {
      logic [BYTE_BITS-1:0] data;
      logic [SEL_W-1:0]     slave;
      logic                 last;
   } sse_req_t;

   // link pins driven by the master
   typedef struct packed {
      logic                  sck;
      logic                  mosi;
      logic [NUM_SLAVES-1:0] sel_n;
   } sse_pins_t;

   typedef enum logic [1:0] {SSE_IDLE, SSE_LEAD, SSE_TRAIL, SSE_GAP} sse_state_t;
endpackage : sse_pkg

// File: verification/spi_shift_exchange_tb.sv
// testbench: spi master against four echoing slave models
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module spi_shift_exchange_tb
   import sse_pkg::*;
;
   logic       clk = 0, srst = 1, cpol = 0, cpha = 0, req_valid = 0;
   logic       req_ready, rx_valid, busy;
   logic [7:0] rx_data, exp_b, exp_q[$], last_b[NUM_SLAVES];
   logic [NUM_SLAVES-1:0] sl_irq;
   logic [1:0] cur_s = '0;
   sse_req_t   req = '0;
   sse_pins_t  pins;
   tri1        miso_w;
   int         miscompares = 0, num_checks = 0, seed = 85;
   always #50 clk = ~clk;
   sse_master dut_u (.clk(clk), .srst(srst), .cpol(cpol), .cpha(cpha), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .miso(miso_w), .pins(pins));
   for (genvar i = 0; i < NUM_SLAVES; i++) begin : g_sl
      sse_slave_model #(.INIT(8'(8'hc3 + i))) sl_u (.sck(pins.sck), .mosi(pins.mosi),
         .sel_n(pins.sel_n[i]), .cpol(cpol), .cpha(cpha), .miso(miso_w),
         .serial_port_irq_flag(sl_irq[i]));
   end
   // scoreboard: a slave returns the byte it last got
   always @(posedge clk) if (rx_valid === 1'b1) begin
      exp_b = exp_q.pop_front();
      `CHK(rx_data, exp_b);
      `CHK(sl_irq[cur_s], 1'b1);
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   // hold the request until ready is seen at an edge
   task automatic send(input logic [7:0] d, input logic [1:0] s, input logic l);
      int n;
      req = '{data: d, slave: s, last: l};
      req_valid = 1'b1;
      exp_q.push_back(last_b[s]);
      last_b[s] = d;
      n = 0;
      do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 200);
      if (n >= 200) miscompares++;
      #1 if (l) req_valid = 1'b0;
   endtask : send
   // chained bytes to one random slave, then wait for idle
   task automatic burst(input int nb);
      logic [1:0] s;
      int n;
      s = 2'($random(seed));
      cur_s = s;
      for (int i = 0; i < nb; i++) send(8'($random(seed)), s, i == nb - 1);
      n = 0;
      while (busy !== 1'b0 && n < 500) begin @(posedge clk); #1; n++; end
      if (n >= 500) miscompares++;
      `CHK(pins.sel_n, SEL_NONE);
      `CHK(pins.sck, cpol);
   endtask : burst
   // all four clock modes, high polarity last
   initial begin
      for (int i = 0; i < NUM_SLAVES; i++) last_b[i] = 8'hc3 + 8'(i);
      repeat (20) @(posedge clk);
      #1 srst = 0;
      `CHK(pins, {2'b00, SEL_NONE});
      for (int m = 0; m < 4; m++) begin
         cpol = m[1];
         cpha = m[0];
         // let the idle clock settle to the new polarity before any select falls
         repeat (2) @(posedge clk);
         #1;
         for (int b = 1; b <= 3; b++) burst(b);
      end
      `CHK(exp_q.size(), 0);
      final_report();
   end
   // watchdog well beyond the expected run
   initial begin
      #2_000_000;
      miscompares++;
      final_report();
   end
endmodule : spi_shift_exchange_tb

// File: verification/sse_master_chk.sv
// checker: link-side assertions for the spi master
`timescale 1ns/1ps
module sse_master_chk
   import sse_pkg::*;
(
   input wire logic      clk,
   input wire logic      srst,
   input wire logic      cpol,
   input wire sse_req_t  req,
   input wire logic      req_valid,
   input wire logic      req_ready,
   input wire logic      rx_valid,
   input wire logic      busy,
   input wire sse_pins_t pins
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // select and clock relations on the link
   one_sel_a: assert property ($onehot0(~pins.sel_n))
      else $error("two selects low");
   sck_half_a: assert property ($changed(pins.sck) |=> $stable(pins.sck) [*3])
      else $error("short half period");
   sck_sel_a: assert property ($changed(pins.sck) && $past(busy) |-> pins.sel_n != SEL_NONE)
      else $error("clock without select");
   idle_pol_a: assert property (!busy |=> pins.sck == $past(cpol))
      else $error("idle clock off polarity");
   stop_drop_a: assert property ($rose(&pins.sel_n) |-> $past(pins.sck, 3) == pins.sck)
      else $error("select dropped while clocking");
   // completion pulse and request taking
   rxv_pulse_a: assert property (rx_valid |=> !rx_valid)
      else $error("rx pulse too long");
   rxv_sel_a: assert property (rx_valid |-> busy && pins.sel_n != SEL_NONE)
      else $error("rx outside burst");
   ready_idle_a: assert property (!busy |-> req_ready)
      else $error("idle but not ready");
   take_sel_a: assert property (req_valid && req_ready && !busy |=>
      pins.sel_n == ~(NUM_SLAVES'(1) << $past(req.slave)))
      else $error("wrong select");
   cover property (rx_valid);
   cover property ($rose(&pins.sel_n));
   cover property (req_valid && req_ready && busy);
endmodule : sse_master_chk

bind sse_master sse_master_chk chk_u (.clk(clk), .srst(srst), .cpol(cpol), .req(req), .req_valid(req_valid),
   .req_ready(req_ready), .rx_valid(rx_valid), .busy(busy), .pins(pins));

// File: verification/sse_slave_model.sv
// slave model: echoes each byte it receives
`timescale 1ns/1ps
module sse_slave_model
   import sse_pkg::*;
#(
   parameter logic [7:0] INIT = 8'h00
)(
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic sel_n,
   input  wire logic cpol,
   input  wire logic cpha,
   output wire logic miso,
   output wire logic serial_port_irq_flag
);
   logic [7:0] sr_reg = INIT;
   logic       out_reg = 1'b0;
   int         rx_bits = 0;
   wire        smp_w = sck ^ cpol ^ cpha;
   // sample edge: shift in at lsb; never makes a clock itself
   always @(posedge smp_w) if (!sel_n) begin
      sr_reg  <= {sr_reg[6:0], mosi};
      rx_bits <= rx_bits + 1;
   end
   // pending from a completed byte until the next bit comes in
   assign serial_port_irq_flag = (rx_bits != 0) && (rx_bits % 8 == 0);
   // launch edge: present msb, also on select
   always @(negedge smp_w or negedge sel_n) if (!sel_n) out_reg <= sr_reg[7];
   // released line floats to the pull-up on the net
   assign miso = sel_n ? 1'bz : out_reg;
endmodule : sse_slave_model
